// ==== temp_i2c_defines.vh ====
// constants for the temperature sensor serial slave port
`ifndef TEMP_I2C_DEFINES_VH
`define TEMP_I2C_DEFINES_VH

// slave address: fixed upper five bits
`define ADDR_FIXED_HI 5'h12
`define GCALL_ADDR 7'h00
`define GCALL_RESET_CODE 8'h06
`define SOFT_RESET_PTR 8'h2F

// register offsets
`define REG_TEMP_HI 8'h00
`define REG_TEMP_LO 8'h01
`define REG_STATUS 8'h02
`define REG_CONFIG 8'h03
`define REG_HIGH_HI 8'h04
`define REG_HIGH_LO 8'h05
`define REG_LOW_HI 8'h06
`define REG_LOW_LO 8'h07
`define REG_CRIT_HI 8'h08
`define REG_CRIT_LO 8'h09
`define REG_HYST 8'h0A
`define REG_ID 8'h0B
`define REG_COUNT 12

// reset values
`define RST_CONFIG 8'h00
`define RST_HIGH_HI 8'h20
`define RST_HIGH_LO 8'h00
`define RST_LOW_HI 8'h05
`define RST_LOW_LO 8'h00
`define RST_CRIT_HI 8'h49
`define RST_CRIT_LO 8'h80
`define RST_HYST 8'h05
`define RST_PTR 8'h00
// identification byte: value arbitrary
`define ID_VALUE 8'hA5

// default reload busy time
`define RELOAD_TIME_NS 200000
`define CLK_PERIOD_NS 25
`define RELOAD_CYCLES ((`RELOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== line_sync.v ====
// two-stage sampler with edge detection for one bus line
`timescale 1ns/1ps
module line_sync (
   // clock and reset
   input wire clk_sys,
   input wire srst,
   // line
   input wire line_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // settle the line before edges are judged; idle level is high
   always @(posedge clk_sys) begin
      if (srst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= line_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign level = s2_q;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;
endmodule // line_sync

// ==== reg_bank.v ====
// sensor register bank with registered read data
`timescale 1ns/1ps
`include "temp_i2c_defines.vh"
module reg_bank (
   // clock and reset
   input wire clk_sys,
   input wire srst,
   input wire reload,
   // write port
   input wire wr_en,
   input wire [7:0] wr_addr,
   input wire [7:0] wr_data,
   // read port
   input wire [7:0] rd_addr,
   output reg [7:0] rd_data,
   // sensor side
   input wire [15:0] temp_value,
   input wire [7:0] status_value,
   output wire [7:0] config_value,
   output wire [15:0] high_limit_setpoint,
   output wire [15:0] low_limit_setpoint,
   output wire [15:0] critical_limit_setpoint,
   output wire [7:0] hysteresis_setpoint
);
   reg [7:0] cfg_q;
   reg [7:0] hh_q;
   reg [7:0] hl_q;
   reg [7:0] lh_q;
   reg [7:0] ll_q;
   reg [7:0] ch_q;
   reg [7:0] cl_q;
   reg [7:0] hy_q;

   // writable registers; reload restores every default
   always @(posedge clk_sys) begin
      if (srst || reload) begin
         cfg_q <= `RST_CONFIG;
         hh_q <= `RST_HIGH_HI;
         hl_q <= `RST_HIGH_LO;
         lh_q <= `RST_LOW_HI;
         ll_q <= `RST_LOW_LO;
         ch_q <= `RST_CRIT_HI;
         cl_q <= `RST_CRIT_LO;
         hy_q <= `RST_HYST;
      end else if (wr_en) begin
         case (wr_addr)
            `REG_CONFIG: cfg_q <= wr_data;
            `REG_HIGH_HI: hh_q <= wr_data;
            `REG_HIGH_LO: hl_q <= wr_data;
            `REG_LOW_HI: lh_q <= wr_data;
            `REG_LOW_LO: ll_q <= wr_data;
            `REG_CRIT_HI: ch_q <= wr_data;
            `REG_CRIT_LO: cl_q <= wr_data;
            `REG_HYST: hy_q <= wr_data;
            default: ;
         endcase
      end
   end

   // read mux; unmapped pointers give zero
   always @(posedge clk_sys) begin
      if (srst) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            `REG_TEMP_HI: rd_data <= temp_value[15:8];
            `REG_TEMP_LO: rd_data <= temp_value[7:0];
            `REG_STATUS: rd_data <= status_value;
            `REG_CONFIG: rd_data <= cfg_q;
            `REG_HIGH_HI: rd_data <= hh_q;
            `REG_HIGH_LO: rd_data <= hl_q;
            `REG_LOW_HI: rd_data <= lh_q;
            `REG_LOW_LO: rd_data <= ll_q;
            `REG_CRIT_HI: rd_data <= ch_q;
            `REG_CRIT_LO: rd_data <= cl_q;
            `REG_HYST: rd_data <= hy_q;
            `REG_ID: rd_data <= `ID_VALUE;
            default: rd_data <= 8'h00;
         endcase
      end
   end

   assign config_value = cfg_q;
   assign high_limit_setpoint = {hh_q, hl_q};
   assign low_limit_setpoint = {lh_q, ll_q};
   assign critical_limit_setpoint = {ch_q, cl_q};
   assign hysteresis_setpoint = hy_q;
endmodule // reg_bank

// ==== temp_sensor_i2c_slave_port.v ====
// serial slave port of the temperature sensor
`timescale 1ns/1ps
`include "temp_i2c_defines.vh"
module temp_sensor_i2c_slave_port #(
   parameter RELOAD_CYCLES = `RELOAD_CYCLES
) (
   // clock and reset
   input wire clk_sys,
   input wire srst,
   // bus pins; data output enable is low while pulling the line low
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_n,
   // address select straps
   input wire addr_select_bit0_pin,
   input wire addr_select_bit1_pin,
   // sensor side
   input wire [15:0] temp_value,
   input wire [7:0] status_value,
   output wire [7:0] config_value,
   output wire [15:0] high_limit_setpoint,
   output wire [15:0] low_limit_setpoint,
   output wire [15:0] critical_limit_setpoint,
   output wire [7:0] hysteresis_setpoint,
   output wire reload_busy
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_WRITE = 3'd2;
   localparam ST_READ = 3'd3;
   localparam ST_GCALL = 3'd4;
   // the span is cut on purpose: the busy counter is 18 bits wide
   localparam [31:0] RELOAD_SPAN = RELOAD_CYCLES - 1;
   localparam [17:0] RELOAD_LAST = RELOAD_SPAN[17:0];

   wire scl;
   wire scl_rise;
   wire scl_fall;
   wire sda;
   wire sda_rise;
   wire sda_fall;
   wire [7:0] rd_data;
   wire start_cond;
   wire stop_cond;
   wire [6:0] own_addr;
   wire [7:0] rd_addr;

   reg [2:0] state_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   reg [7:0] ptr_q;
   reg [1:0] wcount_q;
   reg rx_ack_q;
   reg pull_q;
   reg tx_q;
   reg [7:0] tx_byte_q;
   reg [17:0] busy_cnt_q;
   reg busy_q;
   reg reload_q;
   reg wr_en_q;
   reg [7:0] wr_addr_q;
   reg [7:0] wr_data_q;
   reg rd_step_q;

   // scl and sda see the same sampler delay, so edges keep their order
   line_sync u_scl (
      .clk_sys(clk_sys),
      .srst(srst),
      .line_in(scl_in),
      .level(scl),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   line_sync u_sda (
      .clk_sys(clk_sys),
      .srst(srst),
      .line_in(sda_in),
      .level(sda),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   reg_bank u_bank (
      .clk_sys(clk_sys),
      .srst(srst),
      .reload(reload_q),
      .wr_en(wr_en_q),
      .wr_addr(wr_addr_q),
      .wr_data(wr_data_q),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .temp_value(temp_value),
      .status_value(status_value),
      .config_value(config_value),
      .high_limit_setpoint(high_limit_setpoint),
      .low_limit_setpoint(low_limit_setpoint),
      .critical_limit_setpoint(critical_limit_setpoint),
      .hysteresis_setpoint(hysteresis_setpoint)
   );

   assign own_addr = {`ADDR_FIXED_HI, addr_select_bit1_pin,
      addr_select_bit0_pin};
   assign start_cond = sda_fall & scl;
   assign stop_cond = sda_rise & scl;
   // read address steps past the upper byte; the pointer itself stays put
   assign rd_addr = ptr_q + {7'h00, rd_step_q};

   // upper byte of a two-byte register: offsets 0x00, 0x04, 0x06 and 0x08
   function is_pair_hi;
      input [7:0] a;
      begin
         is_pair_hi = (a == `REG_TEMP_HI) || (a == `REG_HIGH_HI) ||
            (a == `REG_LOW_HI) || (a == `REG_CRIT_HI);
      end
   endfunction

   // writable limit pair upper bytes
   function is_limit_hi;
      input [7:0] a;
      begin
         is_limit_hi = (a == `REG_HIGH_HI) || (a == `REG_LOW_HI) ||
            (a == `REG_CRIT_HI);
      end
   endfunction

   // reload timer: while it runs no address is acknowledged
   always @(posedge clk_sys) begin
      if (srst) begin
         busy_q <= 1'b1;
         busy_cnt_q <= 18'h00000;
      end else if (reload_q) begin
         busy_q <= 1'b1;
         busy_cnt_q <= 18'h00000;
      end else if (busy_q) begin
         if (busy_cnt_q == RELOAD_LAST) begin
            busy_q <= 1'b0;
         end else begin
            busy_cnt_q <= busy_cnt_q + 18'h00001;
         end
      end
   end

   // byte engine; bit_q counts clock rises 0..8 within a byte
   always @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= `RST_PTR;
         wcount_q <= 2'd0;
         rx_ack_q <= 1'b0;
         pull_q <= 1'b0;
         tx_q <= 1'b0;
         tx_byte_q <= 8'h00;
         reload_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         rd_step_q <= 1'b0;
      end else begin
         reload_q <= 1'b0;
         wr_en_q <= 1'b0;
         if (reload_q) begin
            ptr_q <= `RST_PTR;
         end
         if (start_cond) begin
            // a repeated start also lands here and resets direction
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            pull_q <= 1'b0;
            tx_q <= 1'b0;
            rx_ack_q <= 1'b0;
            rd_step_q <= 1'b0;
         end else if (stop_cond) begin
            state_q <= ST_IDLE;
            pull_q <= 1'b0;
            tx_q <= 1'b0;
         end else if (state_q != ST_IDLE && scl_rise) begin
            if (bit_q == 4'd8) begin
               bit_q <= 4'h0;
               // ninth clock: acknowledge slot
               if (state_q == ST_READ && sda) begin
                  state_q <= ST_IDLE;
               end
               rx_ack_q <= 1'b0;
            end else begin
               shift_q <= {shift_q[6:0], sda};
               bit_q <= bit_q + 4'h1;
            end
         end else if (state_q != ST_IDLE && scl_fall) begin
            if (bit_q == 4'd8 && !rx_ack_q) begin
               // end of eighth bit: decide on acknowledge
               rx_ack_q <= 1'b1;
               tx_q <= 1'b0;
               pull_q <= 1'b0;
               case (state_q)
                  ST_ADDR: begin
                     if (!busy_q && shift_q[7:1] == own_addr) begin
                        pull_q <= 1'b1;
                        if (shift_q[0]) begin
                           // reads start at the pointer
                           state_q <= ST_READ;
                        end else begin
                           state_q <= ST_WRITE;
                           wcount_q <= 2'd0;
                        end
                     end else if (!busy_q && !shift_q[0] &&
                        shift_q[7:1] == `GCALL_ADDR) begin
                        pull_q <= 1'b1;
                        state_q <= ST_GCALL;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
                  ST_WRITE: begin
                     if (busy_q) begin
                        // bytes that arrive while reloading are refused
                        state_q <= ST_IDLE;
                     end else if (wcount_q == 2'd0) begin
                        ptr_q <= shift_q;
                        wcount_q <= 2'd1;
                        pull_q <= 1'b1;
                        if (shift_q == `SOFT_RESET_PTR) begin
                           reload_q <= 1'b1;
                        end
                     end else if (wcount_q == 2'd1) begin
                        wr_en_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= shift_q;
                        pull_q <= 1'b1;
                        if (is_limit_hi(ptr_q)) begin
                           wcount_q <= 2'd2;
                        end else begin
                           wcount_q <= 2'd3;
                        end
                     end else if (wcount_q == 2'd2) begin
                        wr_en_q <= 1'b1;
                        wr_addr_q <= ptr_q + 8'h01;
                        wr_data_q <= shift_q;
                        pull_q <= 1'b1;
                        wcount_q <= 2'd3;
                     end else begin
                        // extra bytes are acknowledged and dropped
                        pull_q <= 1'b1;
                     end
                  end
                  ST_GCALL: begin
                     if (shift_q == `GCALL_RESET_CODE && !busy_q) begin
                        // stay out of idle so the ack is released again
                        pull_q <= 1'b1;
                        reload_q <= 1'b1;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
                  default: ;
               endcase
            end else if (state_q == ST_READ && bit_q == 4'd0) begin
               // clock low after address ack or master ack: load byte
               tx_q <= 1'b1;
               tx_byte_q <= {rd_data[6:0], 1'b0};
               pull_q <= ~rd_data[7];
               // rd_data follows the step one clock later, long before
               // the lower byte is loaded
               if (is_pair_hi(ptr_q) && !rd_step_q) begin
                  rd_step_q <= 1'b1;
               end
            end else if (tx_q && state_q == ST_READ) begin
               pull_q <= ~tx_byte_q[7];
               tx_byte_q <= {tx_byte_q[6:0], 1'b0};
            end else begin
               // release after the acknowledge slot
               pull_q <= 1'b0;
               tx_q <= 1'b0;
            end
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_n = ~pull_q;
   assign reload_busy = busy_q;
endmodule // temp_sensor_i2c_slave_port

// ==== port_monitor.sv ====
// pin-level assertions for the sensor serial port
`timescale 1ns/1ps
`include "temp_i2c_defines.vh"
module port_monitor #(
   parameter int RELOAD_CYCLES = 400
) (
   // clock and reset
   input logic clk_sys,
   input logic srst,
   // bus pins
   input logic scl_in,
   input logic sda_in,
   input logic sda_out,
   input logic sda_oe_n,
   // register contents
   input logic [7:0] config_value,
   input logic [15:0] high_limit_setpoint,
   input logic [7:0] hysteresis_setpoint,
   input logic reload_busy
);
   localparam int BUSY_MAX = RELOAD_CYCLES + 4;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // open drain: the pin value is only ever low
   a_pull_low_only: assert property (sda_out == 1'b0)
      else $error("data output value not low");
   // leaving reset the line is free and config and hysteresis hold defaults
   a_reset_idle: assert property ($fell(srst) |-> sda_oe_n &&
      config_value == `RST_CONFIG && hysteresis_setpoint == `RST_HYST)
      else $error("state after reset wrong");
   a_busy_after_reset: assert property ($fell(srst) |-> ##2 reload_busy[*8])
      else $error("reload not busy after reset");
   // no acknowledge may start while defaults are reloading
   a_busy_no_ack: assert property ($fell(sda_oe_n) |-> !reload_busy)
      else $error("line pulled while reloading");
   // the pull may only change while the bus clock is low
   a_drive_scl_low: assert property ($changed(sda_oe_n) |->
      !scl_in && !$past(scl_in)) else $error("pull changed with clock high");
   a_stop_released: assert property ($rose(sda_in) && scl_in |->
      sda_oe_n[*4]) else $error("line pulled after stop");
   a_reload_bounded: assert property ($rose(reload_busy) |->
      ##[1:BUSY_MAX] !reload_busy) else $error("reload never ends");
   a_reload_defaults: assert property ($rose(reload_busy) |-> ##[0:3]
      (config_value == `RST_CONFIG &&
      high_limit_setpoint == {`RST_HIGH_HI, `RST_HIGH_LO}))
      else $error("reload left registers changed");

   // main scenarios seen
   c_ack: cover property ($fell(sda_oe_n));
   c_reload: cover property ($rose(reload_busy));
   c_limit_write: cover property ($changed(high_limit_setpoint));
endmodule // port_monitor

// ==== bus_master_model.sv ====
// behavioural bus master that drives clock and data as open drain
`timescale 1ns/1ps
module bus_master_model #(
   parameter int HALF = 10
) (
   // clock
   input logic clk_sys,
   // bus; a released line reads high through the pull-up
   input logic sda_line,
   output logic scl_o,
   output logic sda_o
);
   // bus idles released
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // start or repeated start: data falls while clock is high
   task start_c;
      sda_o <= 1'b1;
      hold(HALF);
      scl_o <= 1'b1;
      hold(HALF);
      sda_o <= 1'b0;
      hold(HALF);
      scl_o <= 1'b0;
      hold(2);
   endtask
   // one bit: data set in clock low, sampled at the end of clock high
   task bit_x(input logic b, output logic r);
      sda_o <= b;
      hold(HALF);
      scl_o <= 1'b1;
      hold(HALF);
      r = sda_line;
      scl_o <= 1'b0;
      hold(2); // data moves only after the clock fall is seen
   endtask
   // eight bits MSB first, then the acknowledge slot
   task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
      output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]);
      bit_x(ack_in, ack_out);
   endtask
   // stop: data rises while clock is high
   task stop_c;
      sda_o <= 1'b0;
      hold(HALF);
      scl_o <= 1'b1;
      hold(HALF);
      sda_o <= 1'b1;
      hold(HALF);
   endtask
endmodule // bus_master_model

// ==== temp_sensor_i2c_slave_port_tb.sv ====
// self-checking bench for the sensor serial port
`timescale 1ns/1ps
`include "temp_i2c_defines.vh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
   fails++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module temp_sensor_i2c_slave_port_tb;
   localparam int RELOAD = 400;
   typedef struct {logic [7:0] ptr; int n; logic [15:0] exp;} row_t;
   logic clk_sys, srst, sda_out, sda_oe_n, reload_busy, ak;
   logic [1:0] sel;
   logic [7:0] config_value, hysteresis_setpoint, q;
   logic [15:0] high_limit_setpoint, low_limit_setpoint, v;
   logic [15:0] critical_limit_setpoint;
   logic scl_o, sda_o;
   wire sda_line = sda_o & (sda_oe_n | sda_out);
   int fails = 0;
   int cmp_count = 0;
   row_t rows[10];

   // 40 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   temp_sensor_i2c_slave_port #(.RELOAD_CYCLES(RELOAD)) dut_u (
      .clk_sys(clk_sys), .srst(srst), .scl_in(scl_o), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .addr_select_bit0_pin(sel[0]), .addr_select_bit1_pin(sel[1]),
      .temp_value(16'h1234), .status_value(8'h5A),
      .config_value(config_value), .high_limit_setpoint(high_limit_setpoint),
      .low_limit_setpoint(low_limit_setpoint),
      .critical_limit_setpoint(critical_limit_setpoint),
      .hysteresis_setpoint(hysteresis_setpoint), .reload_busy(reload_busy));
   bus_master_model m_u (.clk_sys(clk_sys), .sda_line(sda_line),
      .scl_o(scl_o), .sda_o(sda_o));

   task put(input logic [7:0] b);
      m_u.xfer(b, 1'b1, q, ak);
   endtask
   // pointer byte then n data bytes, upper first
   task wreg(input logic [7:0] p, input int n, input logic [15:0] d);
      m_u.start_c();
      put({`ADDR_FIXED_HI, sel, 1'b0});
      `CHK(ak, 1'b0)
      put(p);
      for (int i = 0; i < n; i++)
         put(i == 0 ? d[15:8] : d[7:0]);
      m_u.stop_c();
   endtask
   // read n bytes, acking all but the last
   task rreg(input int n);
      v = 16'h0000;
      m_u.start_c();
      put({`ADDR_FIXED_HI, sel, 1'b1});
      `CHK(ak, 1'b0)
      m_u.xfer(8'hFF, n == 1, q, ak);
      v[15:8] = q;
      if (n == 2) begin
         m_u.xfer(8'hFF, 1'b1, q, ak);
         v[7:0] = q;
      end
      m_u.stop_c();
   endtask
   // wait out the reload, bounded
   task wait_free;
      for (int k = 0; k < 2 * RELOAD && reload_busy !== 1'b0; k++)
         @(posedge clk_sys);
      `CHK(reload_busy, 1'b0)
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog, well past the expected run length
   initial begin
      #1500000;
      fails++;
      conclude();
   end

   // main sequence: table of reads, then hand-written cases
   initial begin
      srst = 1'b1;
      sel = 2'b00;
      rows = '{'{8'h00, 2, 16'h1234}, '{8'h02, 1, 16'h5A00},
         '{8'h03, 1, 16'h0000}, '{8'h04, 2, 16'h2000}, '{8'h06, 2, 16'h0500},
         '{8'h08, 2, 16'h4980}, '{8'h0A, 1, 16'h0500}, '{8'h0B, 1, 16'hA500},
         '{8'h0C, 1, 16'h0000}, '{8'h05, 1, 16'h0000}};
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      wait_free();
      foreach (rows[i]) begin
         wreg(rows[i].ptr, 0, 16'h0000);
         rreg(rows[i].n);
         `CHK(v, rows[i].exp)
      end
      // limit pair plus a surplus byte
      wreg(8'h04, 3, 16'h3C7E);
      `CHK(high_limit_setpoint, 16'h3C7E)
      `CHK(low_limit_setpoint, {`RST_LOW_HI, `RST_LOW_LO})
      wreg(8'h04, 0, 16'h0000);
      rreg(2);
      `CHK(v, 16'h3C7E)
      rreg(2);
      `CHK(v, 16'h3C7E)
      wreg(8'h08, 2, 16'h1122);
      `CHK(critical_limit_setpoint, 16'h1122)
      wreg(8'h0A, 2, 16'h0709);
      `CHK(hysteresis_setpoint, 8'h07)
      wreg(8'h03, 1, 16'h6000);
      `CHK(config_value, 8'h60)
      // repeated reads need no new pointer
      for (int k = 0; k < 2; k++) begin
         rreg(1);
         `CHK(v[15:8], 8'h60)
      end
      // pointer then read across a repeated start
      m_u.start_c();
      put({`ADDR_FIXED_HI, sel, 1'b0});
      put(8'h0A);
      m_u.start_c();
      put({`ADDR_FIXED_HI, sel, 1'b1});
      m_u.xfer(8'hFF, 1'b1, q, ak);
      m_u.stop_c();
      `CHK(q, 8'h07)
      // each strap setting: own address acked, the other not
      for (int k = 0; k < 4; k++) begin
         sel <= k[1:0];
         m_u.start_c();
         put({`ADDR_FIXED_HI, k[1:0], 1'b0});
         `CHK(ak, 1'b0)
         m_u.start_c();
         put({`ADDR_FIXED_HI, ~k[1:0], 1'b0});
         `CHK(ak, 1'b1)
         m_u.stop_c();
      end
      // general call: read refused, foreign byte refused, reset accepted
      m_u.start_c();
      put(8'h01);
      `CHK(ak, 1'b1)
      m_u.start_c();
      put(8'h00);
      `CHK(ak, 1'b0)
      put(8'h04);
      `CHK(ak, 1'b1)
      m_u.start_c();
      put(8'h00);
      put(`GCALL_RESET_CODE);
      `CHK(ak, 1'b0)
      m_u.stop_c();
      `CHK(sda_oe_n, 1'b1)
      `CHK(reload_busy, 1'b1)
      wait_free();
      `CHK(hysteresis_setpoint, `RST_HYST)
      `CHK(critical_limit_setpoint, {`RST_CRIT_HI, `RST_CRIT_LO})
      // software reset, address refused while reloading
      wreg(8'h03, 1, 16'h2000);
      wreg(`SOFT_RESET_PTR, 0, 16'h0000);
      `CHK(reload_busy, 1'b1)
      m_u.start_c();
      put({`ADDR_FIXED_HI, sel, 1'b0});
      `CHK(ak, 1'b1)
      m_u.stop_c();
      wait_free();
      `CHK(config_value, `RST_CONFIG)
      rreg(2);
      `CHK(v, 16'h1234)
      // mid-run reset: defaults back, pointer cleared
      wreg(8'h0A, 1, 16'h0300);
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      `CHK(hysteresis_setpoint, `RST_HYST)
      wait_free();
      rreg(2);
      `CHK(v, 16'h1234)
      conclude();
   end
endmodule // temp_sensor_i2c_slave_port_tb

bind temp_sensor_i2c_slave_port port_monitor
   #(.RELOAD_CYCLES(RELOAD_CYCLES)) mon_u (
   .clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .config_value(config_value),
   .high_limit_setpoint(high_limit_setpoint),
   .hysteresis_setpoint(hysteresis_setpoint), .reload_busy(reload_busy));
